//--- retentive_updown_counter.v
// Chosen here: the Wishbone interface to the registers and the register addresses.
`include "updown_counter_defs.vh"
`default_nettype none
// Overview of operation
// (R1) Counting up, mode 3 stops counting and sets the coil once count equals preset.
// (R2) Modes 3 and 4 keep the count over power loss for instances 1 to 31.
// (R3) Modes 3 and 4 keep the count over run/stop when retain is set.
// (R4) Retentive reset loads zero counting up, preset counting down.
// (R5) Mode 4 keeps counting past the preset and retains over power loss.
// (R6) Mode 5 coil is on exactly while count is at least the preset.
// (R7) Mode 5 clears to zero on reset, power loss and run/stop; never retains.
// (R8) Count on pulse rising edges; down counts stop at zero.
// (R9) Counting up, overflow modes set coil at preset and count up to 65535.
// (R10) Direction low increments, high decrements.
module retentive_updown_counter (
    input wire clk,
    input wire srst,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    output wire wb_err_o,
    input wire countPulse,
    input wire countDown,
    input wire counterReset,
    input wire powerRestore,
    input wire runStopSwitch,
    output reg outputCoil_q
);
    // ***************************************
    // Input synchronisers
    // ***************************************
    reg [1:0] pulseMeta_q, dirMeta_q, rstMeta_q, pwrMeta_q, rsMeta_q;
    reg pulseLast_q, pwrLast_q, rsLast_q;
    always @(posedge clk) begin
        if (srst) begin
            pulseMeta_q <= 2'h0;
            dirMeta_q <= 2'h0;
            rstMeta_q <= 2'h0;
            pwrMeta_q <= 2'h0;
            rsMeta_q <= 2'h0;
            pulseLast_q <= 1'h0;
            pwrLast_q <= 1'h0;
            rsLast_q <= 1'h0;
        end else begin
            pulseMeta_q <= {pulseMeta_q[0], countPulse};
            dirMeta_q <= {dirMeta_q[0], countDown};
            rstMeta_q <= {rstMeta_q[0], counterReset};
            pwrMeta_q <= {pwrMeta_q[0], powerRestore};
            rsMeta_q <= {rsMeta_q[0], runStopSwitch};
            pulseLast_q <= pulseMeta_q[1];
            pwrLast_q <= pwrMeta_q[1];
            rsLast_q <= rsMeta_q[1];
        end
    end
    // Every pin input crosses two flip-flops, so a pulse is counted on the third edge after it rises.
    wire pulseRise = pulseMeta_q[1] & ~pulseLast_q;
    wire pwrRise = pwrMeta_q[1] & ~pwrLast_q;
    wire rsRise = rsMeta_q[1] & ~rsLast_q;
    wire dirDown = dirMeta_q[1];
    wire resetLevel = rstMeta_q[1];

    // ***************************************
    // Registers
    // ***************************************
    reg [31:0] ctrl_q;
    reg [15:0] preset_q, count_q, count_d;
    wire [2:0] mode = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire retainSet = ctrl_q[`CTRL_RETAIN_BIT];
    wire [7:0] inst = ctrl_q[`CTRL_INST_MSB:`CTRL_INST_LSB];
    wire kept = (mode == `MODE_SAT_KEPT) || (mode == `MODE_OVF_KEPT);
    // Instance zero is left out although the store holds a word for it, so only instances one to thirty-one qualify.
    // (R2) First 31 only
    wire powerDownRetainFlag = kept && (inst != 8'h00) && (inst <= `RETAIN_INSTANCES);
    wire reqValid = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [7:0] offs = wb_adr_i[7:0];
    wire mapped = (wb_adr_i[31:8] == 24'h000000) && (offs[1:0] == 2'h0) && (offs <= `REG_STATUS);
    wire wrCtrl = reqValid & wb_we_i & mapped & (offs == `REG_CTRL);
    wire wrPreset = reqValid & wb_we_i & mapped & (offs == `REG_PRESET);
    wire wrCount = reqValid & wb_we_i & mapped & (offs == `REG_COUNT);
    reg errPend_q;
    assign wb_err_o = errPend_q;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] neww;
        input [3:0] sel;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                merge[i*8 +: 8] = sel[i] ? neww[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    // Value the count takes on reset or reinitialisation.
    function [15:0] initValue;
        input [2:0] m;
        input down;
        input [15:0] pre;
        begin
            // (R4) Reset load value
            if (m != `MODE_CMP && down) begin
                initValue = pre;
            end else begin
                // (R7) Comparison clears
                initValue = `COUNT_ZERO;
            end
        end
    endfunction

    wire [31:0] ctrlMerged = merge(ctrl_q, wb_dat_i, wb_sel_i);
    wire [31:0] presetMerged = merge({16'h0000, preset_q}, wb_dat_i, wb_sel_i);
    wire [31:0] countMerged = merge({16'h0000, count_q}, wb_dat_i, wb_sel_i);

    // ***************************************
    // Power-loss store
    // ***************************************
    // The store is rewritten every cycle while powerDownRetainFlag is set and read through a register, so a restore returns the count
    // of two cycles earlier; a pulse counted in that gap is lost, which keeps the store to one write port and one registered read port.
    wire [15:0] storedCount;
    retain_store u_store (
        .clk(clk),
        .wrEn(powerDownRetainFlag),
        .wrAddr(inst[4:0]),
        .wrData(count_q),
        .rdAddr(inst[4:0]),
        .rdData_q(storedCount)
    );

    // ***************************************
    // Counting
    // ***************************************
    // Power and run/stop edges outrank the reset level; a reset that is still held reloads the count a cycle later.
    always @* begin
        count_d = count_q;
        if (pwrRise) begin
            // (R2) Restore after power
            count_d = powerDownRetainFlag ? storedCount : initValue(mode, dirDown, preset_q);
        end else if (rsRise) begin
            // (R3) Retain over run/stop
            if (!(kept && retainSet)) begin
                count_d = initValue(mode, dirDown, preset_q);
            end
        end else if (resetLevel) begin
            count_d = initValue(mode, dirDown, preset_q);
        end else if (wrCount) begin
            count_d = countMerged[15:0];
        end else if (pulseRise) begin
            // (R10) Direction select
            if (dirDown) begin
                // (R8) Stop at zero
                if (count_q != `COUNT_ZERO) begin
                    count_d = count_q - 16'h0001;
                end
            end else if (mode == `MODE_SAT_KEPT) begin
                // (R1) Saturate at preset
                if (count_q < preset_q) begin
                    count_d = count_q + 16'h0001;
                end
            end else begin
                // (R5) (R9) Count to ceiling
                if (count_q != `COUNT_CEIL) begin
                    count_d = count_q + 16'h0001;
                end
            end
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            ctrl_q <= `CTRL_RESET;
            preset_q <= `PRESET_RESET;
            count_q <= `COUNT_ZERO;
            outputCoil_q <= 1'b0;
        end else begin
            count_q <= count_d;
            if (wrCtrl) begin
                ctrl_q <= ctrlMerged;
            end
            if (wrPreset) begin
                preset_q <= presetMerged[15:0];
            end
            if (mode == `MODE_CMP) begin
                // (R6) Compare coil
                outputCoil_q <= (count_d >= preset_q);
            end else if (dirDown) begin
                outputCoil_q <= (count_d == `COUNT_ZERO);
            end else begin
                // (R1) (R9) Coil at preset
                outputCoil_q <= (count_d >= preset_q);
            end
        end
    end

    // ***************************************
    // Wishbone slave
    // ***************************************
    always @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            errPend_q <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= reqValid & mapped;
            errPend_q <= wb_cyc_i & wb_stb_i & ~errPend_q & ~wb_ack_o & ~mapped;
            // Read data load only when a request is taken, so they hold still between transfers.
            if (reqValid) begin
                case (offs)
                    `REG_CTRL: wb_dat_o <= ctrl_q;
                    `REG_PRESET: wb_dat_o <= {16'h0000, preset_q};
                    `REG_COUNT: wb_dat_o <= {16'h0000, count_q};
                    `REG_STATUS: wb_dat_o <= {29'h0000000, powerDownRetainFlag, dirDown, outputCoil_q};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // retentive_updown_counter
`default_nettype wire

//--- updown_counter_defs.vh
`ifndef UPDOWN_COUNTER_DEFS_VH
`define UPDOWN_COUNTER_DEFS_VH
// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_PRESET 8'h04
`define REG_COUNT 8'h08
`define REG_STATUS 8'h0C
// Control fields.
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_RETAIN_BIT 4
`define CTRL_INST_LSB 8
`define CTRL_INST_MSB 15
// Modes.
`define MODE_SAT_KEPT 3'h3
`define MODE_OVF_KEPT 3'h4
`define MODE_CMP 3'h5
// Limits and reset values.
`define COUNT_CEIL 16'hFFFF
`define COUNT_ZERO 16'h0000
`define RETAIN_INSTANCES 8'h1F
`define CTRL_RESET 32'h00000103
`define PRESET_RESET 16'h0014
`define MEM_DEPTH 32
`endif

//--- retain_store.v
`default_nettype none
// Small store that models count memory surviving power loss, one word per instance.
module retain_store (
    input wire clk,
    input wire wrEn,
    input wire [4:0] wrAddr,
    input wire [15:0] wrData,
    input wire [4:0] rdAddr,
    output reg [15:0] rdData_q
);
    reg [15:0] mem [0:31];
    always @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData_q <= mem[rdAddr];
    end
endmodule // retain_store
`default_nettype wire

//--- updown_counter_checker.sv
`default_nettype none
// ****************
// Port checker
// ****************
module updown_counter_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic [31:0] wb_adr_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic countPulse,
    input wire logic countDown,
    input wire logic counterReset,
    input wire logic powerRestore,
    input wire logic runStopSwitch,
    input wire logic outputCoil_q
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);
    logic [2:0] idle_q;
    // Seven quiet cycles outlast the input synchroniser, so only a real event may move the coil.
    always_ff @(posedge clk)
        idle_q <= (srst || wb_cyc_i || !$stable({countPulse, countDown, counterReset, powerRestore, runStopSwitch})) ?
            3'h0 : idle_q + {2'h0, idle_q != 3'h7};
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ERR_ONE: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
    AST_ONE_ANS: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
    AST_ANS_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("no answer");
    AST_NO_REQ: assert property (wb_ack_o || wb_err_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray answer");
    AST_ACK_MAP: assert property (wb_ack_o |-> $past(wb_adr_i) <= 32'h0000000C) else $error("ack off map");
    AST_DAT_HOLD: assert property (!(wb_cyc_i && wb_stb_i) ##1 !(wb_cyc_i && wb_stb_i) |-> $stable(wb_dat_o))
        else $error("data moved");
    AST_COIL_HOLD: assert property (idle_q == 3'h7 |=> $stable(outputCoil_q)) else $error("coil moved");
    COV_ERR: cover property (wb_err_o);
    COV_COIL_ON: cover property ($rose(outputCoil_q));
    COV_COIL_OFF: cover property ($fell(outputCoil_q));
endmodule // updown_counter_checker
bind retentive_updown_counter updown_counter_checker u_chk (.clk, .srst, .wb_adr_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .countPulse, .countDown, .counterReset, .powerRestore, .runStopSwitch, .outputCoil_q);
`default_nettype wire

//--- tb_retentive_updown_counter.sv
`include "updown_counter_defs.vh"
`default_nettype none
// ****************
// Counter bench
// ****************
module tb_retentive_updown_counter;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, srst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o, wb_err_o;
    logic countPulse = 1'h0, countDown = 1'h0, counterReset = 1'h0, powerRestore = 1'h0, runStopSwitch = 1'h0;
    logic outputCoil_q;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
    int failures = 0, samples_checked = 0;
    always #4 clk = ~clk;
    retentive_updown_counter u_dut (.clk, .srst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i(4'hF), .wb_we_i,
        .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .countPulse, .countDown, .counterReset, .powerRestore,
        .runStopSwitch, .outputCoil_q);
    task close_out;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // A write is judged by its error flag, a read by its data.
    task bus(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [31:0] e);
        int n;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, 24'h0, a, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && n < 50);
        if (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1) begin
            failures++;
            close_out();
        end
        chk(w ? {31'h0, wb_err_o} : wb_dat_o, e);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask
    // Event kinds: 0 run/stop, 1 power back, 2 reset, 3 count pulse; e holds coil and count.
    task step(input int w, input int n, input logic [16:0] e);
        repeat (n) begin
            if (w == 0) runStopSwitch <= 1'h1;
            else if (w == 1) powerRestore <= 1'h1;
            else if (w == 2) counterReset <= 1'h1;
            else countPulse <= 1'h1;
            repeat (6) @(posedge clk);
            {runStopSwitch, powerRestore, counterReset, countPulse} <= 4'h0;
            // The quiet phase outlasts the checker's seven-cycle coil hold window.
            repeat (8) @(posedge clk);
        end
        bus(`REG_COUNT, 32'h0, 1'h0, {16'h0, e[15:0]});
        chk({31'h0, outputCoil_q}, {31'h0, e[16]});
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'h0;
        bus(`REG_CTRL, 32'h0, 1'h0, `CTRL_RESET);
        bus(`REG_PRESET, 32'h5, 1'h1, 32'h0);
        bus(`REG_PRESET, 32'h0, 1'h0, 32'h5);
        step(3, 7, 17'h10005);
        countDown <= 1'h1;
        step(2, 1, 17'h00005);
        step(3, 7, 17'h10000);
        countDown <= 1'h0;
        bus(`REG_CTRL, 32'h104, 1'h1, 32'h0);
        step(3, 7, 17'h10007);
        step(1, 1, 17'h10007);
        bus(`REG_STATUS, 32'h0, 1'h0, 32'h5);
        step(0, 1, 17'h00000);
        step(3, 2, 17'h00002);
        bus(`REG_CTRL, 32'h114, 1'h1, 32'h0);
        step(0, 1, 17'h00002);
        bus(`REG_CTRL, 32'h2004, 1'h1, 32'h0);
        step(1, 1, 17'h00000);
        bus(`REG_COUNT, 32'hFFFE, 1'h1, 32'h0);
        step(3, 3, 17'h1FFFF);
        bus(`REG_CTRL, 32'h115, 1'h1, 32'h0);
        bus(`REG_COUNT, 32'h4, 1'h1, 32'h0);
        step(3, 1, 17'h10005);
        countDown <= 1'h1;
        step(3, 1, 17'h00004);
        bus(`REG_STATUS, 32'h0, 1'h0, 32'h2);
        step(2, 1, 17'h00000);
        for (int w = 0; w < 2; w++) begin
            bus(`REG_COUNT, 32'h9, 1'h1, 32'h0);
            step(w, 1, 17'h00000);
        end
        bus(8'h10, 32'h0, 1'h1, 32'h1);
        close_out();
    end
endmodule // tb_retentive_updown_counter
`default_nettype wire
